//--- src/bcsf_pkg.sv
// package: command codes, directions and carrier types for the command filter
package bcsf_pkg;
   localparam logic [3:0] CMD_INT_ACK = 4'h0;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_RSV4 = 4'h4;
   localparam logic [3:0] CMD_RSV5 = 4'h5;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_RSV8 = 4'h8;
   localparam logic [3:0] CMD_RSV9 = 4'h9;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RDM = 4'hc;
   localparam logic [3:0] CMD_DAC = 4'hd;
   localparam logic [3:0] CMD_MEM_RDL = 4'he;
   localparam logic [3:0] CMD_MEM_WRI = 4'hf;
   localparam int BUS_UP = 0;
   localparam int BUS_DOWN = 1;
   localparam logic FILT_RESET = 1'b0;
   // one command query on one bus
   typedef struct packed {
      logic valid;
      logic [3:0] cmd;
      logic type1;
      logic hit;
   } bcsf_query_t;
   // filter answer for one bus
   typedef struct packed {
      logic init_ok;
      logic claim_ok;
      logic medium_devsel;
   } bcsf_verdict_t;
endpackage

//--- src/bcsf_decode.sv
// combinational command legality table for one bus
`timescale 1ns/1ns
module bcsf_decode #(
   parameter int BUS = 0
) (
   // query in
   input wire bcsf_pkg::bcsf_query_t q,
   // verdict out
   output logic init_ok,
   output logic claim_ok
);
   import bcsf_pkg::*;
   always_comb begin
      init_ok = 1'b0;
      claim_ok = 1'b0;
      case (q.cmd)
         CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
         CMD_MEM_RDM, CMD_DAC, CMD_MEM_RDL, CMD_MEM_WRI: begin
            init_ok = 1'b1;
            claim_ok = 1'b1;
         end
         CMD_SPECIAL: begin
            init_ok = 1'b1;
            claim_ok = 1'b0;
         end
         CMD_CFG_RD: begin
            init_ok = (BUS == BUS_DOWN);
            claim_ok = (BUS == BUS_UP);
         end
         CMD_CFG_WR: begin
            init_ok = (BUS == BUS_DOWN) || q.type1;
            claim_ok = (BUS == BUS_UP) || q.type1;
         end
         default: begin
            init_ok = 1'b0;
            claim_ok = 1'b0;
         end
      endcase
   end
endmodule // bcsf_decode

//--- src/bcsf_filter.sv
// command filter for both bridge buses with registered verdicts
`timescale 1ns/1ns
// Behaviour
// - reserved codes never initiated nor claimed
// - interrupt acknowledge never issued, never claimed
// - special cycles never claimed as target
// - special cycles made only from type-1 config
// - upstream master: only type-1 config writes
// - downstream target: only type-1 config writes
// - io, memory, dual address allowed everywhere
// - upstream claims all config; downstream initiates
// - positive decode only, medium devsel timing
module bcsf_filter (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // queries from bridge decode logic
   input wire bcsf_pkg::bcsf_query_t up_q,
   input wire bcsf_pkg::bcsf_query_t down_q,
   // verdicts
   output bcsf_pkg::bcsf_verdict_t up_v,
   output bcsf_pkg::bcsf_verdict_t down_v,
   // special cycle conversion request on the target bus
   output logic up_special_go,
   output logic down_special_go
);
   import bcsf_pkg::*;
   logic [1:0] init_w, claim_w;
   bcsf_query_t q_w [2];
   bcsf_verdict_t v_reg [2];
   bcsf_verdict_t v_next [2];
   logic [1:0] sp_reg, sp_next;
   assign q_w[0] = up_q;
   assign q_w[1] = down_q;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_bus
         bcsf_decode #(.BUS(g)) u_dec (
            .q(q_w[g]),
            .init_ok(init_w[g]),
            .claim_ok(claim_w[g])
         );
      end
   endgenerate
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         v_next[i].init_ok = q_w[i].valid & init_w[i];
         // claim needs a positive address hit; never subtractive
         v_next[i].claim_ok = q_w[i].valid & claim_w[i] & q_w[i].hit;
         v_next[i].medium_devsel = 1'b1;
         // any hit type-1 config write counts as a special-cycle message, converted on the far bus
         sp_next[i] = q_w[i].valid & q_w[i].hit & q_w[i].type1 &
                      (q_w[i].cmd == CMD_CFG_WR);
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 2; i++) begin
            v_reg[i] <= '0;
         end
         sp_reg <= {2{FILT_RESET}};
      end else if (clk_en) begin
         v_reg <= v_next;
         sp_reg <= sp_next;
      end
   end
   assign up_v = v_reg[0];
   assign down_v = v_reg[1];
   // a message seen on one bus is issued on the other
   assign down_special_go = sp_reg[0];
   assign up_special_go = sp_reg[1];

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   rsv_claim_a: assert property (clk_en && up_q.valid && (up_q.cmd == CMD_RSV4 ||
      up_q.cmd == CMD_RSV5 || up_q.cmd == CMD_RSV8 || up_q.cmd == CMD_RSV9)
      |=> !up_v.init_ok && !up_v.claim_ok) else $error("reserved code accepted");
   intack_down_a: assert property (clk_en && down_q.cmd == CMD_INT_ACK
      |=> !down_v.init_ok && !down_v.claim_ok) else $error("int ack accepted");
   special_claim_a: assert property (clk_en && down_q.cmd == CMD_SPECIAL
      |=> !down_v.claim_ok) else $error("special cycle claimed");
   special_conv_a: assert property (clk_en && up_q.valid && up_q.hit && up_q.type1 &&
      up_q.cmd == CMD_CFG_WR |=> down_special_go) else $error("no conversion");
   up_cfg_init_a: assert property (clk_en && up_q.valid && up_q.cmd == CMD_CFG_WR
      |=> up_v.init_ok == $past(up_q.type1)) else $error("upstream cfg master");
   down_cfg_claim_a: assert property (clk_en && down_q.cmd == CMD_CFG_RD
      |=> !down_v.claim_ok) else $error("downstream cfg read claimed");
   mem_both_a: assert property (clk_en && down_q.valid && down_q.hit &&
      down_q.cmd == CMD_MEM_WR |=> down_v.init_ok && down_v.claim_ok)
      else $error("memory write refused");
   up_cfg_claim_a: assert property (clk_en && up_q.valid && up_q.hit &&
      up_q.cmd == CMD_CFG_RD |=> up_v.claim_ok) else $error("cfg read not claimed");
   pos_decode_a: assert property (clk_en && !up_q.hit |=> !up_v.claim_ok)
      else $error("claim without hit");
   hold_freeze_a: assert property (!clk_en |=> $stable(up_v) && $stable(down_v))
      else $error("state moved while frozen");
   // mirror checks for the other bus, since each bus decodes on its own, plus medium devsel timing on both buses
   rsv_down_a: assert property (clk_en && down_q.valid && (down_q.cmd == CMD_RSV4 ||
      down_q.cmd == CMD_RSV5 || down_q.cmd == CMD_RSV8 || down_q.cmd == CMD_RSV9)
      |=> !down_v.init_ok && !down_v.claim_ok) else $error("reserved code accepted");
   intack_up_a: assert property (clk_en && up_q.cmd == CMD_INT_ACK
      |=> !up_v.init_ok && !up_v.claim_ok) else $error("int ack accepted");
   special_up_a: assert property (clk_en && up_q.cmd == CMD_SPECIAL
      |=> !up_v.claim_ok) else $error("special cycle claimed");
   conv_up_a: assert property (clk_en && down_q.valid && down_q.hit && down_q.type1 &&
      down_q.cmd == CMD_CFG_WR |=> up_special_go) else $error("no conversion");
   down_cfg_wr_a: assert property (clk_en && down_q.valid && down_q.hit &&
      down_q.cmd == CMD_CFG_WR |=> down_v.claim_ok == $past(down_q.type1))
      else $error("downstream cfg write claim");
   down_cfg_init_a: assert property (clk_en && down_q.valid && down_q.cmd == CMD_CFG_RD
      |=> down_v.init_ok) else $error("downstream cfg read not mastered");
   mem_up_a: assert property (clk_en && up_q.valid && up_q.hit &&
      up_q.cmd == CMD_MEM_RD |=> up_v.init_ok && up_v.claim_ok)
      else $error("memory read refused");
   pos_down_a: assert property (clk_en && !down_q.hit |=> !down_v.claim_ok)
      else $error("claim without hit");
   devsel_med_a: assert property (clk_en |=> up_v.medium_devsel && down_v.medium_devsel)
      else $error("devsel timing not medium");
   up_claim_c: cover property (up_v.claim_ok);
   down_init_c: cover property (down_v.init_ok);
   special_c: cover property (down_special_go);
   up_special_c: cover property (up_special_go);
endmodule // bcsf_filter

//--- sim/bcsf_peer.sv
// bus agent model: presents command queries to the filter
`timescale 1ns/1ns
module bcsf_peer (
   // command from the bench {valid,cmd,type1,hit}
   input wire logic [6:0] r,
   // query to the filter
   output bcsf_pkg::bcsf_query_t q
);
   import bcsf_pkg::*;
   // idle bus shows scrambled lines, not the last command
   assign q = r[6] ? r : {1'b0, ~r[5:0]};
endmodule // bcsf_peer

//--- sim/tb.sv
// bench: command table sweep, special conversion, reset and idle checks
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   import bcsf_pkg::*;
   logic core_clk = 0, rst_n = 0, clk_en = 1;
   logic [6:0] up_r = 0, dn_r = 0;
   bcsf_query_t up_q, down_q;
   bcsf_verdict_t up_v, down_v;
   logic up_special_go, down_special_go;
   int err_count = 0, tests_run = 0, cyc = 0;
   bcsf_peer up_p (.r(up_r), .q(up_q));
   bcsf_peer dn_p (.r(dn_r), .q(down_q));
   bcsf_filter dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .up_q(up_q),
      .down_q(down_q), .up_v(up_v), .down_v(down_v), .up_special_go(up_special_go),
      .down_special_go(down_special_go));
   initial forever #25 core_clk = ~core_clk;
   function automatic logic [1:0] exp_v(int bus, logic [6:0] r);
      logic [3:0] c;
      logic i, k;
      c = r[5:2];
      i = !(c inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9});
      k = i && c != CMD_SPECIAL;
      if (c == CMD_CFG_RD) begin
         i = bus == BUS_DOWN;
         k = bus == BUS_UP;
      end
      if (c == CMD_CFG_WR) begin
         i = bus == BUS_DOWN || r[1];
         k = bus == BUS_UP || r[1];
      end
      return {i & r[6], k & r[6] & r[0]};
   endfunction
   function automatic logic conv(logic [6:0] r);
      return r[6] && r[0] && r[1] && r[5:2] == CMD_CFG_WR;
   endfunction
   task automatic sweep();
      for (int n = 0; n < 128; n++) begin
         @(posedge core_clk);
         up_r <= n[6:0];
         dn_r <= n[6:0] ^ 7'h02;
         @(posedge core_clk);
         #1;
         `CHK({up_v.init_ok, up_v.claim_ok}, exp_v(BUS_UP, up_r))
         `CHK({down_v.init_ok, down_v.claim_ok}, exp_v(BUS_DOWN, dn_r))
         `CHK(up_special_go, conv(dn_r))
         `CHK(down_special_go, conv(up_r))
      end
   endtask
   task automatic idle_freeze();
      @(posedge core_clk);
      up_r <= 7'h59;
      clk_en <= 0;
      @(posedge core_clk);
      #1;
      // the idle edge after release already set medium timing
      `CHK(up_v, 3'h1)
      @(posedge core_clk);
      clk_en <= 1;
      @(posedge core_clk);
      #1;
      `CHK(up_v, 3'h7)
   endtask
   task automatic reset_mid();
      @(posedge core_clk);
      up_r <= 7'h6f;
      rst_n <= 0;
      @(posedge core_clk);
      #1;
      `CHK({up_v, down_v, up_special_go, down_special_go}, 8'h00)
      @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      #1;
      `CHK({up_v, down_special_go}, 4'hf)
      `CHK(down_v.medium_devsel, 1'b1)
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      `CHK(up_v, 3'h0)
      rst_n <= 1;
      idle_freeze();
      sweep();
      reset_mid();
      close_out();
   end
endmodule // tb
